// ==== core/jtl_tx_link.sv ====
`timescale 1ns/1ps
`include "jtl_map.svh"
module jtl_tx_link
    import jtl_pkg::*;
#(
    parameter int         LANES     = 4,
    parameter int         F         = 2,
    parameter int         K         = 32,
    parameter int         M         = 2,
    parameter int         S         = 1,
    parameter int         NRES      = 14,
    parameter int         CS        = 0,
    parameter int         NP        = 16,
    parameter int         HD        = 0,
    parameter int         CF        = 0,
    parameter logic [7:0] DEVICE_ID = 8'h00,
    parameter logic [3:0] BANK_ID   = 4'h0
)(
    // Clock and reset.
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Pins from the receiver and the system, asynchronous to mclk.
    input  wire logic                       syncRequestNPos,
    input  wire logic                       syncRequestNNeg,
    input  wire logic                       sysrefIn,
    // Configuration port.
    input  wire logic                       cfgWrite,
    input  wire logic                       cfgScrambleEnable,
    input  wire logic                       cfgAlignCharSubstitutionEnable,
    input  wire logic                       cfgSyncCmos,
    // Sample stream, one sample per lane per frame.
    input  wire logic                       sampleValid,
    output logic                            sampleReady,
    input  wire logic [LANES*(NRES+CS)-1:0] sampleData,
    // Lane symbols and link state.
    output jtl_sym_t                        laneSym [LANES],
    output jtl_phase_t                      linkPhase
);
    localparam int SW   = NRES + CS;
    localparam int TAIL = NP - NRES - CS;
    localparam int OW   = (F > 1) ? $clog2(F) : 1;
    localparam int KW   = $clog2(K);

    jtl_phase_t        phase, next_phase;
    logic [OW-1:0]     octIdx, next_octIdx;
    logic [KW-1:0]     frmIdx, next_frmIdx;
    logic [1:0]        mfIdx, next_mfIdx;
    logic              scrEn, next_scrEn, substEn, next_substEn, syncCmos, next_syncCmos;
    logic [1:0]        syncP, syncN;
    logic [2:0]        sysS;
    logic              syncLevel, sysrefRise, lastOct, lastFrm, lmfcEnd;
    logic              popValid, popReady;
    logic [LANES*SW-1:0] popData;
    int                mfPos;

    // Ten-bit control code chosen by the current running disparity.
    function automatic logic [9:0] kCodeOf(input logic [7:0] ch, input logic rd);
        unique case (ch)
            `JTL_K28_0: kCodeOf = rd ? `JTL_K28_0_POS : `JTL_K28_0_NEG;
            `JTL_K28_3: kCodeOf = rd ? `JTL_K28_3_POS : `JTL_K28_3_NEG;
            `JTL_K28_4: kCodeOf = rd ? `JTL_K28_4_POS : `JTL_K28_4_NEG;
            `JTL_K28_7: kCodeOf = rd ? `JTL_K28_7_POS : `JTL_K28_7_NEG;
            default:    kCodeOf = rd ? `JTL_K28_5_POS : `JTL_K28_5_NEG;
        endcase
    endfunction

    // Link configuration octet; counts other than CS and CF are sent as value minus one.
    function automatic logic [7:0] cfgOct(input int idx, input int lane, input logic scr);
        unique case (idx)
            0:       cfgOct = DEVICE_ID;
            1:       cfgOct = {4'h0, BANK_ID};
            2:       cfgOct = 8'(lane);
            3:       cfgOct = {scr, 2'h0, 5'(LANES-1)};
            4:       cfgOct = 8'(F-1);
            5:       cfgOct = 8'(K-1);
            6:       cfgOct = 8'(M-1);
            7:       cfgOct = {2'(CS), 1'b0, 5'(NRES-1)};
            8:       cfgOct = {`JTL_SUBCLASS, 5'(NP-1)};
            9:       cfgOct = {`JTL_JESDV, 5'(S-1)};
            10:      cfgOct = {1'(HD), 2'h0, 5'(CF)};
            13:      cfgOct = fchk(lane, scr);
            default: cfgOct = 8'h00;
        endcase
    endfunction

    // Checksum is the modulo-256 sum of the preceding configuration octets.
    function automatic logic [7:0] fchk(input int lane, input logic scr);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < `JTL_CFG_OCTETS - 1; i++) begin
            sum = sum + cfgOct(i, lane, scr);
        end
        return sum;
    endfunction

    // Octet-wide step of the self-synchronising 1 + x^14 + x^15 scrambler, MSB first.
    function automatic logic [22:0] scrStep(input logic [7:0] d, input logic [14:0] st);
        logic [14:0] s;
        logic [7:0]  o;
        s = st;
        for (int b = 7; b >= 0; b--) begin
            o[b] = d[b] ^ s[14] ^ s[13];
            s    = {s[13:0], o[b]};
        end
        return {o, s};
    endfunction

    // Two-flop synchronisers; the first stage feeds only the second.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            syncP <= 2'h0;                                           // Reset as a pending request so no false release.
            syncN <= 2'h0;
            sysS  <= 3'h0;
        end else begin
            syncP <= {syncP[0], syncRequestNPos};
            syncN <= {syncN[0], syncRequestNNeg};
            sysS  <= {sysS[1:0], sysrefIn};
        end
    end

    // Differential mode needs both legs to agree; CMOS mode reads only the positive leg, so a floating negative leg is ignored.
    assign syncLevel  = syncCmos ? syncP[1] : (syncP[1] & ~syncN[1]);
    assign sysrefRise = sysS[1] & ~sysS[2];
    assign lastOct    = (octIdx == OW'(F-1));
    assign lastFrm    = (frmIdx == KW'(K-1));
    assign lmfcEnd    = lastOct && lastFrm;
    assign mfPos      = int'(frmIdx) * F + int'(octIdx);
    assign popReady   = (phase == JTL_DATA) && (octIdx == '0);
    assign linkPhase  = phase;

    // Sample buffer; it drains one beat per frame only while user data flows.
    jtl_fifo #(
        .W     (LANES*SW),
        .DEPTH (4)
    ) u_fifo (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   (sampleData),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    // Configuration, multiframe counters and link phase.
    always_comb begin
        next_scrEn    = scrEn;
        next_substEn  = substEn;
        next_syncCmos = syncCmos;
        next_phase    = phase;
        next_mfIdx    = mfIdx;
        next_octIdx   = octIdx;
        next_frmIdx   = frmIdx;
        if (cfgWrite) begin
            next_scrEn    = cfgScrambleEnable;
            next_substEn  = cfgAlignCharSubstitutionEnable;
            next_syncCmos = cfgSyncCmos;
        end
        if (sysrefRise) begin
            next_octIdx = '0;
            next_frmIdx = '0;
        end else begin
            next_octIdx = lastOct ? '0 : octIdx + 1'b1;
            if (lastOct) begin
                next_frmIdx = lastFrm ? '0 : frmIdx + 1'b1;
            end
        end
        unique case (phase)
            JTL_CGS: begin
                if (syncLevel && lmfcEnd && !sysrefRise) begin
                    next_phase = JTL_ILAS;
                    next_mfIdx = 2'h0;
                end
            end
            JTL_ILAS: begin
                if (!syncLevel) begin
                    next_phase = JTL_CGS;
                end else if (lmfcEnd) begin
                    if (mfIdx == `JTL_ILAS_LAST_MF) begin
                        next_phase = JTL_DATA;
                    end else begin
                        next_mfIdx = mfIdx + 1'b1;
                    end
                end
            end
            JTL_DATA: begin
                if (!syncLevel) begin
                    next_phase = JTL_CGS;
                end
            end
            default: next_phase = JTL_CGS;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase    <= JTL_CGS;
            mfIdx    <= 2'h0;
            octIdx   <= '0;
            frmIdx   <= '0;
            scrEn    <= `JTL_SCR_EN_RST;
            substEn  <= `JTL_SUBST_EN_RST;
            syncCmos <= `JTL_CMOS_RST;
        end else begin
            phase    <= next_phase;
            mfIdx    <= next_mfIdx;
            octIdx   <= next_octIdx;
            frmIdx   <= next_frmIdx;
            scrEn    <= next_scrEn;
            substEn  <= next_substEn;
            syncCmos <= next_syncCmos;
        end
    end

    // One symbol path per lane.
    for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
        logic [NP-1:0] word, next_word, cur;
        logic [14:0]   scr, next_scr;
        logic [7:0]    prevLast, next_prevLast, dat, outOct, ch;
        logic [22:0]   so;
        logic          rd, next_rd, isK;
        jtl_sym_t      sym, next_sym;

        always_comb begin
            // An empty buffer at frame start sends zero samples rather than stalling the link.
            cur = (octIdx == '0) ? (popValid ? NP'(popData[ln*SW +: SW]) << TAIL : '0) : word;
            dat           = cur[NP-1-int'(octIdx)*8 -: 8];
            next_word     = cur;
            so            = scrStep(dat, scr);
            outOct        = scrEn ? so[22:15] : dat;
            next_scr      = scr;
            next_prevLast = prevLast;
            isK           = 1'b1;
            ch            = `JTL_K28_5;
            unique case (phase)
                JTL_ILAS: begin
                    isK = 1'b0;
                    ch  = 8'(mfPos);
                    if (mfPos == 0) begin
                        isK = 1'b1;
                        ch  = `JTL_K28_0;
                    end else if (lmfcEnd) begin
                        isK = 1'b1;
                        ch  = `JTL_K28_3;
                    end else if (mfIdx == `JTL_CFG_MF && mfPos == `JTL_Q_POS) begin
                        isK = 1'b1;
                        ch  = `JTL_K28_4;
                    end else if (mfIdx == `JTL_CFG_MF && mfPos >= `JTL_CFG_FIRST &&
                                 mfPos < `JTL_CFG_FIRST + `JTL_CFG_OCTETS) begin
                        ch = cfgOct(mfPos - `JTL_CFG_FIRST, ln, scrEn);
                    end
                end
                JTL_DATA: begin
                    isK = 1'b0;
                    ch  = outOct;
                    if (scrEn) begin
                        next_scr = so[14:0];
                    end
                    if (lastOct) begin
                        next_prevLast = outOct;
                        if (substEn && scrEn) begin
                            if (lastFrm && outOct == `JTL_K28_3) begin
                                isK = 1'b1;
                            end else if (outOct == `JTL_K28_7) begin
                                isK = 1'b1;
                            end
                        end else if (substEn && outOct == prevLast) begin
                            isK = 1'b1;
                            ch  = lastFrm ? `JTL_K28_3 : `JTL_K28_7;
                        end
                    end
                end
                default: ;
            endcase
            // Only control codes are encoded here; data disparity belongs to the data encoder.
            next_sym.isK   = isK;
            next_sym.octet = ch;
            next_sym.kCode = isK ? kCodeOf(ch, rd) : 10'h000;
            next_rd        = (isK && $countones(next_sym.kCode) != `JTL_BALANCED_ONES) ? ~rd : rd;
        end

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                word     <= '0;
                scr      <= `JTL_SCR_SEED;
                prevLast <= 8'h00;
                rd       <= `JTL_RD_RST;
                sym      <= '0;
            end else begin
                word     <= next_word;
                scr      <= next_scr;
                prevLast <= next_prevLast;
                rd       <= next_rd;
                sym      <= next_sym;
            end
        end

        assign laneSym[ln] = sym;
    end

    // Checks on lane 0; all lanes share the same control path.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_cgs_k;
        phase == JTL_CGS |=> laneSym[0].isK && laneSym[0].octet == `JTL_K28_5;
    endproperty
    a_cgs_k: assert property (p_cgs_k) else $error("K28.5 missing in sync phase.");
    property p_low_resync;
        !syncLevel |=> phase == JTL_CGS;
    endproperty
    a_low_resync: assert property (p_low_resync) else $error("Low request did not hold sync phase.");
    property p_ilas_boundary;
        phase == JTL_CGS ##1 phase == JTL_ILAS |-> octIdx == '0 && frmIdx == '0;
    endproperty
    a_ilas_boundary: assert property (p_ilas_boundary) else $error("Alignment off boundary.");
    property p_ilas_r;
        phase == JTL_ILAS && mfPos == 0 |=> laneSym[0].isK && laneSym[0].octet == `JTL_K28_0;
    endproperty
    a_ilas_r: assert property (p_ilas_r) else $error("Multiframe start is not R.");
    property p_ilas_a;
        phase == JTL_ILAS && lmfcEnd |=> laneSym[0].isK && laneSym[0].octet == `JTL_K28_3;
    endproperty
    a_ilas_a: assert property (p_ilas_a) else $error("Multiframe end is not A.");
    property p_ilas_q;
        phase == JTL_ILAS && mfIdx == `JTL_CFG_MF && mfPos == `JTL_Q_POS |=> laneSym[0].octet == `JTL_K28_4;
    endproperty
    a_ilas_q: assert property (p_ilas_q) else $error("Q not second in config multiframe.");
    property p_ramp;
        phase == JTL_ILAS && mfIdx == 2'h0 && mfPos != 0 && !lmfcEnd
            |=> !laneSym[0].isK && laneSym[0].octet == 8'($past(mfPos));
    endproperty
    a_ramp: assert property (p_ramp) else $error("Ramp value wrong.");
    property p_to_data;
        phase == JTL_ILAS && mfIdx == `JTL_ILAS_LAST_MF && lmfcEnd && syncLevel |=> phase == JTL_DATA;
    endproperty
    a_to_data: assert property (p_to_data) else $error("User data did not follow alignment.");
    property p_subst_f;
        phase == JTL_DATA && scrEn && substEn && lastOct && g_lane[0].outOct == `JTL_K28_7
            |=> laneSym[0].isK && laneSym[0].octet == `JTL_K28_7;
    endproperty
    a_subst_f: assert property (p_subst_f) else $error("Frame-end 0xFC not replaced.");
    property p_repeat_a;
        phase == JTL_DATA && !scrEn && substEn && lmfcEnd && g_lane[0].outOct == g_lane[0].prevLast
            |=> laneSym[0].isK && laneSym[0].octet == `JTL_K28_3;
    endproperty
    a_repeat_a: assert property (p_repeat_a) else $error("Repeated multiframe end not A.");
    property p_defaults;
        $rose(rst_n) |-> scrEn && substEn && !syncCmos;
    endproperty
    a_defaults: assert property (p_defaults) else $error("Wrong configuration after reset.");

    c_data: cover property (phase == JTL_ILAS ##1 phase == JTL_DATA);
    c_resync: cover property (phase == JTL_DATA ##1 phase == JTL_CGS);
    c_subst: cover property (phase == JTL_DATA && laneSym[0].isK);
endmodule // jtl_tx_link

// ==== core/jtl_map.svh ====
`ifndef JTL_MAP_SVH
`define JTL_MAP_SVH

// Control character octet values.
`define JTL_K28_0 8'h1C
`define JTL_K28_3 8'h7C
`define JTL_K28_4 8'h9C
`define JTL_K28_5 8'hBC
`define JTL_K28_7 8'hFC

// Ten-bit control codes for negative and positive running disparity.
`define JTL_K28_0_NEG 10'h0F4
`define JTL_K28_0_POS 10'h30B
`define JTL_K28_3_NEG 10'h0F3
`define JTL_K28_3_POS 10'h30C
`define JTL_K28_4_NEG 10'h0F4
`define JTL_K28_4_POS 10'h30D
`define JTL_K28_5_NEG 10'h0FA
`define JTL_K28_5_POS 10'h305
`define JTL_K28_7_NEG 10'h0F8
`define JTL_K28_7_POS 10'h307
`define JTL_BALANCED_ONES 5

// Reset values of the configuration port and of the lane state.
`define JTL_SCR_EN_RST   1'b1
`define JTL_SUBST_EN_RST 1'b1
`define JTL_CMOS_RST     1'b0
`define JTL_RD_RST       1'b0
`define JTL_SCR_SEED     15'h7FFF

// Alignment sequence layout.
`define JTL_ILAS_LAST_MF 2'h3
`define JTL_CFG_MF       2'h1
`define JTL_Q_POS        1
`define JTL_CFG_FIRST    2
`define JTL_CFG_OCTETS   14
`define JTL_SUBCLASS     3'h1
`define JTL_JESDV        3'h1

`endif

// ==== core/jtl_pkg.sv ====
package jtl_pkg;

    // Link phases, Gray coded along the establishment path.
    typedef enum logic [1:0] {
        JTL_CGS  = 2'h0,
        JTL_ILAS = 2'h1,
        JTL_DATA = 2'h3
    } jtl_phase_t;

    // One lane symbol: octet, control flag and ten-bit control code.
    typedef struct packed {
        logic       isK;
        logic [7:0] octet;
        logic [9:0] kCode;
    } jtl_sym_t;

endpackage

// ==== core/jtl_fifo.sv ====
`timescale 1ns/1ps
module jtl_fifo
    import jtl_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 4
)(
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Filling side.
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Draining side.
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [AW:0]   count, next_count;
    logic          push, pop;

    // Full and empty come straight from the occupancy count.
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer wrap and occupancy update.
    always_comb begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        if (push) begin
            next_wrPtr = (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
        end
        if (pop) begin
            next_rdPtr = (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
        end
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; only the pointers and the count need a defined value.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule // jtl_fifo

// ==== testbench/jtl_rx_model.sv ====
`timescale 1ns/1ps
`include "jtl_map.svh"
module jtl_rx_model
    import jtl_pkg::*;
(
    // Clock and reset.
    input  wire logic     mclk,
    input  wire logic     rst_n,
    // Lane zero symbol.
    input  wire jtl_sym_t laneIn,
    // Test controls.
    input  wire logic     forceLow,
    input  wire logic     floatNeg,
    // Request pins.
    output logic          syncPos,
    output logic          syncNeg
);
    logic [2:0] kRun;
    logic       wobble;

    // Count good K symbols; the request is released only after four in a row.
    always @(posedge mclk) begin
        wobble <= rst_n ? ~wobble : 1'b0;
        if (!rst_n || forceLow) begin
            kRun <= 3'h0;
        end else if (kRun != 3'h4) begin
            kRun <= (laneIn.isK === 1'b1 && laneIn.octet === `JTL_K28_5) ? kRun + 3'h1 : 3'h0;
        end
    end

    // Request held low until released; a floating negative leg wanders each cycle.
    assign syncPos = (kRun == 3'h4);
    assign syncNeg = floatNeg ? wobble : ~syncPos;
endmodule // jtl_rx_model

// ==== testbench/jtl_tx_link_test.sv ====
`timescale 1ns/1ps
module jtl_tx_link_test;
    import jtl_pkg::*;
    logic        mclk = 1'b0, rst_n, sPos, sNeg, sysrefIn, cfgWrite, cfgScr, cfgSub, cfgCmos;
    logic        sampleValid, sampleReady, forceLow, floatNeg, active = 1'b0;
    logic [55:0] sampleData, beatVec[4];
    jtl_sym_t    laneSym [4];
    jtl_phase_t  linkPhase;
    logic [35:0] expQ[$], e;
    logic [15:0] pad;
    logic [7:0]  prev[4];
    int          failures = 0, check_count = 0, t;

    jtl_tx_link #(.LANES(4)) dut (.mclk(mclk), .rst_n(rst_n), .syncRequestNPos(sPos), .syncRequestNNeg(sNeg),
        .sysrefIn(sysrefIn), .cfgWrite(cfgWrite), .cfgScrambleEnable(cfgScr),
        .cfgAlignCharSubstitutionEnable(cfgSub), .cfgSyncCmos(cfgCmos), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleData(sampleData), .laneSym(laneSym), .linkPhase(linkPhase));
    jtl_rx_model rx (.mclk(mclk), .rst_n(rst_n), .laneIn(laneSym[0]), .forceLow(forceLow),
        .floatNeg(floatNeg), .syncPos(sPos), .syncNeg(sNeg));

    // Free-running clock.
    always #25 mclk = ~mclk;

    task cmp_sym(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cmp_val(input logic [9:0] got, input logic [9:0] exp);
        cmp_sym({26'h0, got}, {26'h0, exp});
    endtask

    task print_verdict;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [35:0] lanes_now();
        for (int n = 0; n < 4; n++) lanes_now[n*9+:9] = {laneSym[n].isK, laneSym[n].octet};
    endfunction

    // Expected alignment symbol; scrambling is off so the checksum is 8'h80 plus the lane.
    function automatic logic [8:0] ilas_sym(int m, int p, int n);
        logic [7:0] c[14] = '{8'h00, 8'h00, 8'(n), 8'h03, 8'h01, 8'h1F, 8'h01, 8'h0D, 8'h2F, 8'h20,
                              8'h00, 8'h00, 8'h00, 8'(8'h80 + n)};
        if (p == 0) return 9'h11C;
        if (p == 63) return 9'h17C;
        if (m == 1 && p == 1) return 9'h19C;
        if (m == 1 && p >= 2 && p <= 15) return {1'b0, c[p-2]};
        return {1'b0, 8'(p)};
    endfunction

    // Watcher: starts on the first start character and pops one note per cycle.
    always begin
        @(posedge mclk);
        #1;
        if (expQ.size() > 0 && (active || lanes_now() === {4{9'h11C}})) begin
            active = 1'b1;
            cmp_sym(lanes_now(), expQ.pop_front());
        end else active = 1'b0;
    end

    // Main sequence: every input has a value at time zero.
    initial begin
        {rst_n, sysrefIn, cfgWrite, cfgCmos, sampleValid, forceLow, floatNeg} = '0;
        {cfgScr, cfgSub, sampleData} = {2'b11, 56'h0};
        void'($urandom(46));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        cfgWrite <= 1'b1;
        cfgScr <= 1'b0;
        sysrefIn <= 1'b1;
        @(posedge mclk);
        {cfgWrite, sysrefIn} <= 2'b00;
        #1 cmp_sym(lanes_now(), {4{9'h1BC}});
        cmp_val(laneSym[1].kCode, 10'h0FA);
        @(posedge mclk);
        #1 cmp_val(laneSym[2].kCode, 10'h305);
        // Beat ends 04,08,08,10 then empty frames of zeros force F and a final A.
        for (int b = 0; b < 4; b++)
            for (int n = 0; n < 4; n++) beatVec[b][n*14+:14] = {8'($urandom), 6'(b == 2 ? 2 : b + 1)};
        for (int m = 0; m < 4; m++)
            for (int p = 0; p < 64; p++) begin
                for (int n = 0; n < 4; n++) e[n*9+:9] = ilas_sym(m, p, n);
                expQ.push_back(e);
            end
        for (int f = 0; f < 32; f++) begin
            for (int n = 0; n < 4; n++) begin
                pad = (f < 4) ? {beatVec[f][n*14+:14], 2'b00} : 16'h0;
                e[n*9+:9] = {1'b0, pad[15:8]};
                e[(n+4)%4*9+:9] = e[n*9+:9];
            end
            expQ.push_back(e);
            for (int n = 0; n < 4; n++) begin
                pad = (f < 4) ? {beatVec[f][n*14+:14], 2'b00} : 16'h0;
                e[n*9+:9] = (f > 0 && pad[7:0] == prev[n]) ? (f == 31 ? 9'h17C : 9'h1FC) : {1'b0, pad[7:0]};
                prev[n] = pad[7:0];
            end
            expQ.push_back(e);
        end
        @(posedge mclk);
        for (int b = 0; b < 4; b++) begin
            sampleValid <= 1'b1;
            sampleData <= beatVec[b];
            t = 0;
            do @(posedge mclk); while (sampleReady !== 1'b1 && ++t < 50);
            if (t >= 50) failures++;
        end
        sampleValid <= 1'b0;
        #1 cmp_val({9'h0, sampleReady}, 10'h000);
        t = 0;
        while (expQ.size() > 0 && t < 3000) begin
            @(posedge mclk);
            t++;
        end
        if (t >= 3000) failures++;
        #1 cmp_val({8'h00, linkPhase}, {8'h00, JTL_DATA});
        // Single-ended request held low over eight frames while the other leg floats.
        @(posedge mclk);
        {cfgWrite, cfgCmos, floatNeg, forceLow} <= 4'hF;
        @(posedge mclk);
        cfgWrite <= 1'b0;
        repeat (16) @(posedge mclk);
        #1 cmp_val({8'h00, linkPhase}, {8'h00, JTL_CGS});
        cmp_sym(lanes_now(), {4{9'h1BC}});
        @(posedge mclk);
        forceLow <= 1'b0;
        t = 0;
        while (linkPhase !== JTL_ILAS && t < 500) begin
            @(posedge mclk);
            t++;
        end
        #1 cmp_val({8'h00, linkPhase}, {8'h00, JTL_ILAS});
        print_verdict();
    end
endmodule // jtl_tx_link_test
